/* File: dv/fstop_ctrl_model.sv */
// Motion controller model: servo-on and ready-on commands
`timescale 1ns/10ps
module fstop_ctrl_model (
  input  wire logic [1:0] drop,     // Bit 0 withdraws servo-on, bit 1 ready-on
  input  wire logic       clk,      // System clock
  output logic            servo_on, // Servo-on command
  output logic            ready_on  // Ready-on command
);
  // Commands stay on through a stop unless the bench withdraws one
  always_ff @(posedge clk) begin
    servo_on <= !drop[0];
    ready_on <= !drop[1];
  end
endmodule : fstop_ctrl_model

/* File: dv/test_forced_stop_brake_sequencer.sv */
// Bench: runs each stop trigger through the sequencer and checks its outputs
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_forced_stop_brake_sequencer import fstop_pkg::*;;
  localparam int TC  = 2; // Ramp ticks per speed step
  localparam int SPD = 3; // Speed command before a stop
  localparam int DLY = 2; // Base shut-off delay in ticks, set with margin
  logic        clk, sys_rst, ce, fs_pin, alarm, comm_lost, alarm_reset, torque_mode;
  logic        servo_on, ready_on, interlock, base_on, dyn;
  logic [1:0]  drop, state;
  logic [3:0]  sel;
  logic [15:0] spd_meas, cmd;
  logic [7:0]  warn;
  int          err_count, n_compared, cycles;

  forced_stop_brake_sequencer dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .forced_stop_input(fs_pin), .alarm(alarm),
    .comm_lost(comm_lost), .alarm_reset(alarm_reset), .servo_on(servo_on),
    .ready_on(ready_on), .torque_mode(torque_mode), .stop_decel_select(sel),
    .stop_decel_time_constant(16'(TC)), .zero_speed_threshold(16'h0004),
    .base_shutoff_delay(16'(DLY)), .speed_cmd_in(16'(SPD)), .speed_meas(spd_meas),
    .model_speed_cmd(cmd), .brake_interlock_output(interlock), .base_on(base_on),
    .dyn_brake(dyn), .forced_stop_warning(warn), .seq_state(state));

  fstop_ctrl_model ctrl (.drop(drop), .clk(clk), .servo_on(servo_on), .ready_on(ready_on));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_st(input logic [1:0] st, input int lim, output int n);
    n = 0;
    while (state !== st && n < lim) begin
      tick();
      n++;
    end
    `CHK(state, st)
  endtask : wait_st

  // One stop: trigger, optional command withdrawal, reset back to run
  task automatic run_stop(input int k, input logic [1:0] st1, input logic [7:0] w,
                          input logic [1:0] drp);
    int n;
    @(posedge clk);
    comm_lost <= (k == 0);
    fs_pin    <= (k != 1);
    alarm     <= (k == 2);
    spd_meas  <= 16'h0004;
    wait_st(st1, 8, n);
    `CHK(warn, w)
    if (st1 == ST_DECEL) begin
      `CHK({interlock, base_on, dyn}, 3'b110)
    end
    if (st1 == ST_DECEL && drp != 2'b00) begin
      @(posedge clk);
      drop <= drp;
      tick();
      wait_st(ST_OFF, 3, n);
    end else if (st1 == ST_DECEL) begin
      repeat ((SPD - 1) * TC * TICK_CYC - TICK_CYC) tick();
      `CHK(cmd, 16'(SPD - 1))
      repeat (2 * TC * TICK_CYC) tick();
      `CHK(cmd, 16'h0000)
      `CHK(state, ST_DECEL)
      @(posedge clk);
      spd_meas <= 16'h0000;
      tick();
      wait_st(ST_BRAKE, 3, n);
      `CHK({interlock, base_on}, 2'b01)
      wait_st(ST_OFF, (DLY + 2) * TICK_CYC, n);
      `CHK(n >= (DLY - 1) * TICK_CYC, 1'b1)
    end
    `CHK({base_on, dyn, interlock, cmd}, {3'b010, 16'h0000})
    `CHK(warn, w)
    @(posedge clk);
    alarm_reset <= 1'b1;
    @(posedge clk);
    alarm_reset <= 1'b0;
    tick();
    `CHK(state, ST_OFF)
    @(posedge clk);
    comm_lost <= 1'b0;
    fs_pin    <= 1'b1;
    alarm     <= 1'b0;
    drop      <= 2'b00;
    repeat (6) @(posedge clk);
    alarm_reset <= 1'b1;
    @(posedge clk);
    alarm_reset <= 1'b0;
    tick();
    wait_st(ST_RUN, 4, n);
    `CHK({base_on, dyn, interlock, warn}, {3'b101, WARN_CODE_NONE})
  endtask : run_stop

  // Main sequence
  initial begin
    sys_rst     = 1'b1;
    ce          = 1'b1;
    fs_pin      = 1'b1; // Held high between stops, pulled low only for the pin stop
    alarm       = 1'b0;
    comm_lost   = 1'b0;
    alarm_reset = 1'b0;
    torque_mode = 1'b0;
    drop        = 2'b00;
    sel         = SEL_DECEL_ON;
    spd_meas    = 16'h0000;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    tick();
    `CHK({state, interlock, base_on, dyn, warn}, {ST_RUN, 3'b110, WARN_CODE_NONE})
    tick();
    `CHK(cmd, 16'(SPD))
    // Clock enable low freezes the sequencer even with a trigger present
    @(posedge clk);
    ce        <= 1'b0;
    comm_lost <= 1'b1;
    repeat (4) tick();
    `CHK({state, warn}, {ST_RUN, WARN_CODE_NONE})
    @(posedge clk);
    ce        <= 1'b1;
    comm_lost <= 1'b0;
    tick();
    `CHK(state, ST_RUN)
    run_stop(0, ST_DECEL, WARN_CODE_FSTOP, 2'b00);
    run_stop(1, ST_DECEL, WARN_CODE_FSTOP, 2'b00);
    run_stop(2, ST_DECEL, WARN_CODE_NONE, 2'b00);
    run_stop(0, ST_DECEL, WARN_CODE_FSTOP, 2'b01);
    run_stop(1, ST_DECEL, WARN_CODE_FSTOP, 2'b10);
    @(posedge clk);
    sel <= SEL_DECEL_OFF;
    run_stop(2, ST_OFF, WARN_CODE_NONE, 2'b00);
    @(posedge clk);
    sel <= 4'h3;
    run_stop(0, ST_OFF, WARN_CODE_FSTOP, 2'b00);
    @(posedge clk);
    sel         <= SEL_DECEL_ON;
    torque_mode <= 1'b1;
    run_stop(0, ST_OFF, WARN_CODE_FSTOP, 2'b00);
    print_verdict();
  end
endmodule : test_forced_stop_brake_sequencer

/* File: hdl/forced_stop_brake_sequencer.sv */
// Forced stop sequencer: ramp down, brake interlock, base shut-off
`timescale 1ns/10ps
module forced_stop_brake_sequencer
  import fstop_pkg::*;
#(
  parameter int SW = SPEED_W,  // Speed width
  parameter int TW = TC_W,     // Time constant width
  parameter int DW = DLY_W     // Delay width
) (
  input  wire logic          clk,                     // 25 MHz clock
  input  wire logic          sys_rst,                 // Synchronous reset
  input  wire logic          ce,                      // Clock enable
  input  wire logic          forced_stop_input,       // Pin, high = drive allowed
  input  wire logic          alarm,                   // Alarm event level
  input  wire logic          comm_lost,               // Network link lost
  input  wire logic          alarm_reset,             // Error reset command
  input  wire logic          servo_on,                // Servo-on from controller
  input  wire logic          ready_on,                // Ready-on from controller
  input  wire logic          torque_mode,             // Torque control active
  input  wire logic [3:0]    stop_decel_select,       // Leading select digit
  input  wire logic [TW-1:0] stop_decel_time_constant, // Ramp ticks per unit step
  input  wire logic [SW-1:0] zero_speed_threshold,    // Zero speed level
  input  wire logic [DW-1:0] base_shutoff_delay,      // Delay in ticks
  input  wire logic [SW-1:0] speed_cmd_in,            // Normal speed command
  input  wire logic [SW-1:0] speed_meas,              // Measured speed magnitude
  output logic      [SW-1:0] model_speed_cmd,         // Speed command to loop
  output logic               brake_interlock_output,  // High = brake released
  output logic               base_on,                 // Base power enabled
  output logic               dyn_brake,               // Dynamic brake engaged
  output logic [7:0]         forced_stop_warning,     // Status display code
  output logic [1:0]         seq_state                // Sequencer state
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic stop_pin_ok;

  fstop_sync3 u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .rst_val (1'b1),
    .pin     (forced_stop_input),
    .level   (stop_pin_ok)
  );

  // Trigger decode
  logic decel_en;
  logic cmds_ok;
  logic trig;
  logic trig_fs;
  assign decel_en = (stop_decel_select == SEL_DECEL_ON) && !torque_mode;
  assign cmds_ok  = servo_on && ready_on;
  assign trig_fs  = !stop_pin_ok || comm_lost;
  assign trig     = trig_fs || alarm;

  // ----------------------------------------------------------------
  // State and timers
  // ----------------------------------------------------------------
  seq_state_e    st_reg,   st_next;
  logic [4:0]    pre_reg,  pre_next;
  logic [TW-1:0] tc_reg,   tc_next;
  logic [DW-1:0] dly_reg,  dly_next;
  logic [SW-1:0] cmd_reg,  cmd_next;
  logic          fsact_reg, fsact_next;
  logic          tick;
  assign tick = (pre_reg == TICK_CYC_M1);

  // Next state and ramp computation
  always_comb begin
    st_next    = st_reg;
    tc_next    = tc_reg;
    dly_next   = dly_reg;
    cmd_next   = cmd_reg;
    fsact_next = fsact_reg;
    pre_next   = tick ? 5'h00 : pre_reg + 5'h01;
    unique case (st_reg)
      ST_RUN: begin
        cmd_next = speed_cmd_in;
        if (trig) begin
          fsact_next = trig_fs;
          if (!cmds_ok || !decel_en) begin
            st_next = ST_OFF;
          end else begin
            st_next = ST_DECEL;
            tc_next = stop_decel_time_constant;
          end
        end
      end
      ST_DECEL: begin
        if (!cmds_ok) begin
          st_next = ST_OFF;
        end else if (cmd_reg == '0 && speed_meas < zero_speed_threshold) begin
          st_next  = ST_BRAKE;
          dly_next = base_shutoff_delay;
        end else if (tick && cmd_reg != '0) begin
          if (tc_reg <= TW'(1)) begin
            cmd_next = cmd_reg - SW'(1);
            tc_next  = stop_decel_time_constant;
          end else begin
            tc_next = tc_reg - TW'(1);
          end
        end
      end
      ST_BRAKE: begin
        if (!cmds_ok || dly_reg == '0) begin
          st_next = ST_OFF;
        end else if (tick) begin
          dly_next = dly_reg - DW'(1);
        end
      end
      ST_OFF: begin
        cmd_next = '0;
        if (alarm_reset && !trig) begin
          st_next    = ST_RUN;
          fsact_next = 1'b0;
        end
      end
    endcase
    // Speed command drops to zero as soon as base power is cut
    if (st_next == ST_OFF) begin
      cmd_next = '0;
    end
  end

  // State registers, frozen while ce is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg    <= ST_RUN;
      pre_reg   <= 5'h00;
      tc_reg    <= '0;
      dly_reg   <= '0;
      cmd_reg   <= '0;
      fsact_reg <= 1'b0;
    end else if (ce) begin
      st_reg    <= st_next;
      pre_reg   <= pre_next;
      tc_reg    <= tc_next;
      dly_reg   <= dly_next;
      cmd_reg   <= cmd_next;
      fsact_reg <= fsact_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [SW-1:0] mcmd_reg;
  logic          mbr_reg, base_reg, db_reg;
  logic [7:0]    warn_reg;
  logic [7:0]    warn_next;
  logic          mbr_next, base_next, db_next;

  // Output decode from next state
  always_comb begin
    mbr_next  = (st_next == ST_RUN) || (st_next == ST_DECEL);
    base_next = (st_next != ST_OFF);
    db_next   = (st_next == ST_OFF);
    warn_next = (fsact_next && st_next != ST_RUN) ? WARN_CODE_FSTOP
                                                  : WARN_CODE_NONE;
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcmd_reg <= '0;
      mbr_reg  <= 1'b1;
      base_reg <= 1'b1;
      db_reg   <= 1'b0;
      warn_reg <= WARN_CODE_NONE;
    end else if (ce) begin
      mcmd_reg <= cmd_next;
      mbr_reg  <= mbr_next;
      base_reg <= base_next;
      db_reg   <= db_next;
      warn_reg <= warn_next;
    end
  end

  assign model_speed_cmd        = mcmd_reg;
  assign brake_interlock_output = mbr_reg;
  assign base_on                = base_reg;
  assign dyn_brake              = db_reg;
  assign forced_stop_warning    = warn_reg;
  assign seq_state              = st_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_comm_start;
    @(posedge clk) disable iff (sys_rst)
      (ce && st_reg == ST_RUN && comm_lost && cmds_ok && decel_en)
      |=> st_reg == ST_DECEL;
  endproperty
  a_comm_start: assert property (p_comm_start) else $error("comm loss no decel");

  property p_torque;
    @(posedge clk) disable iff (sys_rst)
      (ce && st_reg == ST_RUN && torque_mode) |=> st_reg != ST_DECEL;
  endproperty
  a_torque: assert property (p_torque) else $error("decel in torque mode");

  property p_cmds;
    @(posedge clk) disable iff (sys_rst)
      (ce && (st_reg == ST_DECEL || st_reg == ST_BRAKE) && !cmds_ok) |=> st_reg == ST_OFF;
  endproperty
  a_cmds: assert property (p_cmds) else $error("commands off not skipped");

  property p_ramp;
    @(posedge clk) disable iff (sys_rst)
      (st_reg == ST_DECEL && $past(st_reg) == ST_DECEL) |-> cmd_reg <= $past(cmd_reg);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp rose");

  property p_base_off;
    @(posedge clk) disable iff (sys_rst)
      (st_reg == ST_OFF) |-> (!base_on && dyn_brake);
  endproperty
  a_base_off: assert property (p_base_off) else $error("base not cut");

  property p_warn;
    @(posedge clk) disable iff (sys_rst)
      (fsact_reg && st_reg != ST_RUN) |-> forced_stop_warning == WARN_CODE_FSTOP;
  endproperty
  a_warn: assert property (p_warn) else $error("warning missing");

  property p_alarm;
    @(posedge clk) disable iff (sys_rst)
      (ce && st_reg == ST_RUN && alarm) |=> st_reg != ST_RUN;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm ignored");

  property p_mbr_first;
    @(posedge clk) disable iff (sys_rst)
      $fell(base_on) && $past(st_reg) == ST_BRAKE |-> !$past(brake_interlock_output);
  endproperty
  a_mbr_first: assert property (p_mbr_first) else $error("base off before interlock");

  property p_nodecel;
    @(posedge clk) disable iff (sys_rst)
      (ce && st_reg == ST_RUN && alarm && !decel_en) |=> st_reg == ST_OFF;
  endproperty
  a_nodecel: assert property (p_nodecel) else $error("no direct brake");

  property p_hold_off;
    @(posedge clk) disable iff (sys_rst)
      (st_reg == ST_OFF && !alarm_reset) |=> st_reg == ST_OFF;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("left off without reset");

endmodule : forced_stop_brake_sequencer

/* File: hdl/fstop_pkg.sv */
// Package: constants and types for the forced stop brake sequencer
package fstop_pkg;

  // ----------------------------------------------------------------
  // Widths and settings
  // ----------------------------------------------------------------
  localparam int          SPEED_W          = 16;
  localparam int          TC_W             = 16;
  localparam int          DLY_W            = 16;
  localparam logic [3:0]  SEL_DECEL_ON     = 4'h2;   // Leading digit enabling ramp
  localparam logic [3:0]  SEL_DECEL_OFF    = 4'h0;   // Leading digit disabling ramp
  localparam logic [3:0]  SEL_RESET_VAL    = 4'h2;   // Default leading digit
  localparam logic [7:0]  WARN_CODE_NONE   = 8'h00;  // Display shows no warning
  localparam logic [7:0]  WARN_CODE_FSTOP  = 8'he6;  // Forced stop warning code
  localparam logic [15:0] TICK_US          = 16'h0001; // Ramp and delay unit, us
  localparam int          CLK_MHZ          = 25;
  localparam int          TICK_CYC         = 25;     // TICK_US * CLK_MHZ cycles
  localparam logic [4:0]  TICK_CYC_M1      = 5'h18;  // TICK_CYC - 1

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DECEL = 2'b01,
    ST_BRAKE = 2'b10,
    ST_OFF   = 2'b11
  } seq_state_e;

endpackage : fstop_pkg

/* File: hdl/fstop_sync3.sv */
// Three flop synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
module fstop_sync3 (
  input  wire logic clk,      // System clock
  input  wire logic sys_rst,  // Synchronous reset, active high
  input  wire logic ce,       // Clock enable
  input  wire logic rst_val,  // Level held during reset
  input  wire logic pin,      // Asynchronous pin level
  output logic      level     // Filtered level
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       lvl_reg;
  logic       lvl_next;

  // Shift in and accept a level only when stages two and three agree
  always_comb begin
    sh_next  = sh_reg;
    lvl_next = lvl_reg;
    if (ce) begin
      sh_next = {sh_reg[1:0], pin};
      if (sh_reg[1] == sh_reg[2]) begin
        lvl_next = sh_reg[2];
      end
    end
  end

  // Register stage; reset loads the idle level so no false stop follows reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sh_reg  <= {3{rst_val}};
      lvl_reg <= rst_val;
    end else begin
      sh_reg  <= sh_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level = lvl_reg;
endmodule : fstop_sync3
